// File: include/psc_pkg.sv
// register map, field positions, state codes and timing for the peripheral state control bank
package psc_pkg;
   // register byte addresses
   localparam logic [31:0] ADDR_UNLOCK = 32'h02AC0004;
   localparam logic [31:0] ADDR_PERIPH_CFG = 32'h02AC0008;
   localparam logic [31:0] ADDR_STATE_RPT = 32'h02AC0014;
   localparam logic [31:0] ADDR_PCI_RPT = 32'h02AC0018;
   localparam logic [31:0] ADDR_MEM_CFG = 32'h02AC002C;
   // unlock key and reset value of the key register
   localparam logic [31:0] UNLOCK_KEY = 32'h0F0A0B00;
   localparam logic [31:0] UNLOCK_RESET = 32'hF0F0F0F0;
   // unlock window and memory port enable latency
   localparam int CLK_PERIOD_NS = 10;
   localparam int UNLOCK_WINDOW_CYC = 16;
   localparam int MEM_READY_CYC = 16;
   localparam int ENABLE_PROG_CYC = 4;
   localparam logic [4:0] WINDOW_LAST = 5'(UNLOCK_WINDOW_CYC - 1);
   localparam logic [4:0] MEM_READY_LAST = 5'(MEM_READY_CYC - 1);
   localparam logic [2:0] PROG_LAST = 3'(ENABLE_PROG_CYC - 1);
   // lockable peripheral order: 0 ethernet .. 8 pci
   localparam int NUM_LOCKABLE = 9;
   localparam int IDX_ETH = 0;
   localparam int IDX_HOST = 6;
   localparam int IDX_PCI = 8;
   // enable bit positions in the locked configuration register
   localparam int BIT_PCI = 20;
   localparam int BIT_HOST = 18;
   localparam int BIT_SP1 = 16;
   localparam int BIT_SP0 = 14;
   localparam int BIT_I2C = 12;
   localparam int BIT_GPIO = 10;
   localparam int BIT_TIMER1 = 8;
   localparam int BIT_TIMER0 = 6;
   localparam int BIT_ETH = 4;
   // memory port enable bits
   localparam int BIT_DRAM = 1;
   localparam int BIT_ASYNC = 0;
   // state report fields: lowest bit of each 3-bit field
   localparam int FLD_ETH_LO = 6;
   localparam int FLD_WIDTH = 3;
   localparam int FLD_PCI_LO = 0;
   // boot select codes
   localparam logic [3:0] BOOT_HOST_PORT = 4'h1;
   localparam logic [3:0] BOOT_ASYNC_ROM = 4'h4;
   localparam logic [3:0] BOOT_PCI = 4'h7;
   // status codes
   localparam logic [2:0] ST_DISABLED = 3'h0;
   localparam logic [2:0] ST_ENABLED = 3'h1;
   localparam logic [2:0] ST_POWERDOWN = 3'h3;
   localparam logic [2:0] ST_IN_PROGRESS = 3'h5;
   // per-peripheral state machine
   typedef enum logic [3:0] {
      PS_DISABLED = 4'h1,
      PS_IN_PROGRESS = 4'h2,
      PS_ENABLED = 4'h4,
      PS_POWERDOWN = 4'h8
   } psc_state_e;
endpackage

// File: rtl/psc_top.sv
// peripheral state control bank: locked enables, sticky memory port enables, state reports
// Functional notes
// - bit 20 enables pci; preset by pci boot
// - bit 18 enables host port; preset by host port boot
// - bit 16 enables serial port 1
// - bit 14 enables serial port 0
// - bit 12 enables i2c unit
// - bit 10 enables gpio unit
// - bit 8 enables timer 1
// - bit 6 enables timer 0
// - bit 4 enables ethernet and management
// - memory register: bit1 dram, bit0 async port
// - memory enables sticky until device reset
// - memory units usable within 16 cycles
// - pin-disabled memory units never enable
// - async enable preset by rom boot mode
// - no status fields for memory units
// - 3-bit state fields in report register
// - codes: 000 off,001 on,011 pd,101 progress
// - key unlocks one write within 16 cycles
// - disabled means reset held, clock gated
// - enable passes through in-progress state
`timescale 1ns/1ns
module psc_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // cpu register port
   input wire logic reg_sel,
   input wire logic reg_wr,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // configuration pins
   input wire logic [3:0] boot_select_pins,
   input wire logic [8:0] static_pd_pins,
   input wire logic dram_pin_enable,
   input wire logic async_pin_enable,
   // lockable peripheral controls, index 0 ethernet .. 8 pci
   output logic [8:0] periph_clk_en,
   output logic [8:0] periph_rst_release,
   // memory port controls
   output logic dram_ctrl_ready,
   output logic async_mem_ready
);
   // bit position of each lockable peripheral in the configuration register
   function automatic int cfg_bit(input int idx);
      case (idx)
         0: cfg_bit = psc_pkg::BIT_ETH;
         1: cfg_bit = psc_pkg::BIT_TIMER0;
         2: cfg_bit = psc_pkg::BIT_TIMER1;
         3: cfg_bit = psc_pkg::BIT_GPIO;
         4: cfg_bit = psc_pkg::BIT_I2C;
         5: cfg_bit = psc_pkg::BIT_SP0;
         6: cfg_bit = psc_pkg::BIT_HOST;
         7: cfg_bit = psc_pkg::BIT_SP1;
         default: cfg_bit = psc_pkg::BIT_PCI;
      endcase
   endfunction

   // address match for a write
   function automatic logic wr_hit(input logic [31:0] addr);
      wr_hit = reg_sel && reg_wr && (reg_addr == addr);
   endfunction

   logic [31:0] unlock_q;
   logic armed_q;
   logic [4:0] window_q;
   logic [8:0] enable_q;
   logic dram_en_q;
   logic async_en_q;
   logic boot_seen_q;
   logic [4:0] dram_cnt_q;
   logic [4:0] async_cnt_q;
   logic dram_rdy_q;
   logic async_rdy_q;
   logic [26:0] state_codes;
   logic [31:0] state_rpt;
   logic [31:0] pci_rpt;
   logic [31:0] periph_cfg_rd;
   logic [31:0] mem_cfg_rd;

   // key register and one-shot unlock window
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         unlock_q <= psc_pkg::UNLOCK_RESET;
         armed_q <= 1'b0;
         window_q <= 5'h00;
      end else if (wr_hit(psc_pkg::ADDR_UNLOCK)) begin
         unlock_q <= reg_wdata;
         armed_q <= (reg_wdata == psc_pkg::UNLOCK_KEY);
         window_q <= 5'h00;
      end else if (armed_q) begin
         // single write consumes the unlock, or the window expires
         if (wr_hit(psc_pkg::ADDR_PERIPH_CFG) || window_q == psc_pkg::WINDOW_LAST) begin
            armed_q <= 1'b0;
         end
         window_q <= window_q + 5'h01;
      end
   end

   // boot presets are caught on the first edge after reset release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         boot_seen_q <= 1'b0;
      end else begin
         boot_seen_q <= 1'b1;
      end
   end

   // locked enable register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enable_q <= 9'h000;
      end else if (!boot_seen_q) begin
         enable_q <= 9'h000;
         enable_q[psc_pkg::IDX_PCI] <= (boot_select_pins == psc_pkg::BOOT_PCI);
         enable_q[psc_pkg::IDX_HOST] <= (boot_select_pins == psc_pkg::BOOT_HOST_PORT);
      end else if (wr_hit(psc_pkg::ADDR_PERIPH_CFG) && armed_q) begin
         // writes without a live unlock fall through untouched
         for (int i = 0; i < psc_pkg::NUM_LOCKABLE; i++) begin
            enable_q[i] <= reg_wdata[cfg_bit(i)];
         end
      end
   end

   // sticky memory port enables
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dram_en_q <= 1'b0;
         async_en_q <= 1'b0;
      end else if (!boot_seen_q) begin
         async_en_q <= (boot_select_pins == psc_pkg::BOOT_ASYNC_ROM);
      end else if (wr_hit(psc_pkg::ADDR_MEM_CFG)) begin
         dram_en_q <= dram_en_q | reg_wdata[psc_pkg::BIT_DRAM];
         async_en_q <= async_en_q | reg_wdata[psc_pkg::BIT_ASYNC];
      end
   end

   // memory units come up after a fixed settle count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dram_cnt_q <= 5'h00;
         async_cnt_q <= 5'h00;
         dram_rdy_q <= 1'b0;
         async_rdy_q <= 1'b0;
      end else begin
         if (dram_en_q && dram_pin_enable && !dram_rdy_q) begin
            dram_cnt_q <= dram_cnt_q + 5'h01;
            dram_rdy_q <= (dram_cnt_q == psc_pkg::MEM_READY_LAST - 5'h02);
         end
         if (async_en_q && async_pin_enable && !async_rdy_q) begin
            async_cnt_q <= async_cnt_q + 5'h01;
            async_rdy_q <= (async_cnt_q == psc_pkg::MEM_READY_LAST - 5'h02);
         end
      end
   end

   assign dram_ctrl_ready = dram_rdy_q;
   assign async_mem_ready = async_rdy_q;

   // per-peripheral state machines
   generate
      for (genvar g = 0; g < psc_pkg::NUM_LOCKABLE; g++) begin : g_periph
         psc_pkg::psc_state_e st_q;
         logic [2:0] prog_q;
         logic [2:0] code;

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               st_q <= psc_pkg::PS_DISABLED;
               prog_q <= 3'h0;
            end else begin
               case (st_q)
                  psc_pkg::PS_DISABLED: begin
                     prog_q <= 3'h0;
                     if (static_pd_pins[g]) begin
                        st_q <= psc_pkg::PS_POWERDOWN;
                     end else if (enable_q[g]) begin
                        st_q <= psc_pkg::PS_IN_PROGRESS;
                     end
                  end
                  psc_pkg::PS_IN_PROGRESS: begin
                     prog_q <= prog_q + 3'h1;
                     if (static_pd_pins[g]) begin
                        st_q <= psc_pkg::PS_POWERDOWN;
                     end else if (!enable_q[g]) begin
                        st_q <= psc_pkg::PS_DISABLED;
                     end else if (prog_q == psc_pkg::PROG_LAST) begin
                        st_q <= psc_pkg::PS_ENABLED;
                     end
                  end
                  psc_pkg::PS_ENABLED: begin
                     if (static_pd_pins[g]) begin
                        st_q <= psc_pkg::PS_POWERDOWN;
                     end else if (!enable_q[g]) begin
                        st_q <= psc_pkg::PS_DISABLED;
                     end
                  end
                  psc_pkg::PS_POWERDOWN: begin
                     if (!static_pd_pins[g]) begin
                        st_q <= psc_pkg::PS_DISABLED;
                     end
                  end
                  default: begin
                     st_q <= psc_pkg::PS_DISABLED;
                  end
               endcase
            end
         end

         // state code and gate controls
         always_comb begin
            case (st_q)
               psc_pkg::PS_IN_PROGRESS: code = psc_pkg::ST_IN_PROGRESS;
               psc_pkg::PS_ENABLED: code = psc_pkg::ST_ENABLED;
               psc_pkg::PS_POWERDOWN: code = psc_pkg::ST_POWERDOWN;
               default: code = psc_pkg::ST_DISABLED;
            endcase
         end

         // clock runs from in-progress on; reset released only when enabled
         assign periph_clk_en[g] = (st_q == psc_pkg::PS_IN_PROGRESS) || (st_q == psc_pkg::PS_ENABLED);
         assign periph_rst_release[g] = (st_q == psc_pkg::PS_ENABLED);
         assign state_codes[g*psc_pkg::FLD_WIDTH +: psc_pkg::FLD_WIDTH] = code;
      end
   endgenerate

   // read images; memory units have no status field
   always_comb begin
      state_rpt = 32'h00000000;
      // fields in index order below the host port
      for (int i = 0; i < psc_pkg::IDX_HOST; i++) begin
         state_rpt[psc_pkg::FLD_ETH_LO + i * psc_pkg::FLD_WIDTH +: psc_pkg::FLD_WIDTH] =
            state_codes[i * psc_pkg::FLD_WIDTH +: psc_pkg::FLD_WIDTH];
      end
      // serial port 1 sits below the host port in the report, unlike the index order
      state_rpt[psc_pkg::FLD_ETH_LO + psc_pkg::IDX_HOST * psc_pkg::FLD_WIDTH +: psc_pkg::FLD_WIDTH] =
         state_codes[(psc_pkg::IDX_HOST + 1) * psc_pkg::FLD_WIDTH +: psc_pkg::FLD_WIDTH];
      state_rpt[psc_pkg::FLD_ETH_LO + (psc_pkg::IDX_HOST + 1) * psc_pkg::FLD_WIDTH +: psc_pkg::FLD_WIDTH] =
         state_codes[psc_pkg::IDX_HOST * psc_pkg::FLD_WIDTH +: psc_pkg::FLD_WIDTH];
      pci_rpt = 32'h00000000;
      pci_rpt[psc_pkg::FLD_PCI_LO +: psc_pkg::FLD_WIDTH] = state_codes[26:24];
      periph_cfg_rd = 32'h00000000;
      for (int i = 0; i < psc_pkg::NUM_LOCKABLE; i++) begin
         periph_cfg_rd[cfg_bit(i)] = enable_q[i];
      end
      mem_cfg_rd = 32'h00000000;
      mem_cfg_rd[psc_pkg::BIT_DRAM] = dram_en_q;
      mem_cfg_rd[psc_pkg::BIT_ASYNC] = async_en_q;
   end

   // registered read data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_sel && !reg_wr) begin
         case (reg_addr)
            psc_pkg::ADDR_UNLOCK: reg_rdata <= unlock_q;
            psc_pkg::ADDR_PERIPH_CFG: reg_rdata <= periph_cfg_rd;
            psc_pkg::ADDR_STATE_RPT: reg_rdata <= state_rpt;
            psc_pkg::ADDR_PCI_RPT: reg_rdata <= pci_rpt;
            psc_pkg::ADDR_MEM_CFG: reg_rdata <= mem_cfg_rd;
            default: reg_rdata <= 32'h00000000;
         endcase
      end
   end
endmodule

// File: testbench/psc_top_sva.sv
// assertion checker for the peripheral state control bank
`timescale 1ns/1ns
module psc_top_sva (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // cpu register port
   input wire logic reg_sel,
   input wire logic reg_wr,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   // configuration pins
   input wire logic [3:0] boot_select_pins,
   input wire logic [8:0] static_pd_pins,
   input wire logic dram_pin_enable,
   input wire logic async_pin_enable,
   // unit controls
   input wire logic [8:0] periph_clk_en,
   input wire logic [8:0] periph_rst_release,
   input wire logic dram_ctrl_ready,
   input wire logic async_mem_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [2:0] wr_age_q;
   // cycles since the last locked config write, saturating
   always_ff @(posedge clk or posedge rst) begin
      if (rst) wr_age_q <= 3'h7;
      else if (reg_sel && reg_wr && reg_addr == psc_pkg::ADDR_PERIPH_CFG) wr_age_q <= 3'h0;
      else if (wr_age_q != 3'h7) wr_age_q <= wr_age_q + 3'h1;
   end
   // read request at an address
   sequence s_rd(a);
      reg_sel && !reg_wr && reg_addr == a;
   endsequence
   // i2c clock on while still in reset
   sequence s_prog;
      periph_clk_en[4] && !periph_rst_release[4];
   endsequence
   AST_ASYNC_STICKY: assert property (async_mem_ready |=> async_mem_ready)
      else $error("async port ready dropped");
   AST_DRAM_STRAP: assert property (!dram_pin_enable |-> !dram_ctrl_ready)
      else $error("strapped-off dram unit enabled");
   AST_ASYNC_STRAP: assert property (!async_pin_enable |-> !async_mem_ready)
      else $error("strapped-off async port enabled");
   AST_ASYNC_LAT: assert property (reg_sel && reg_wr && reg_addr == psc_pkg::ADDR_MEM_CFG && reg_wdata[0]
      && async_pin_enable |-> ##[1:16] async_mem_ready) else $error("async port not ready in time");
   AST_DRAM_LAT: assert property (reg_sel && reg_wr && reg_addr == psc_pkg::ADDR_MEM_CFG && reg_wdata[1]
      && dram_pin_enable |-> ##[1:16] dram_ctrl_ready) else $error("dram unit not ready in time");
   AST_CLK_BEFORE_REL: assert property ((periph_rst_release & ~periph_clk_en) == 9'h0)
      else $error("reset released with clock gated");
   AST_PD_OFF: assert property ((static_pd_pins & $past(static_pd_pins) & periph_clk_en) == 9'h0)
      else $error("powered-down unit clocked");
   AST_I2C_PROG: assert property ($rose(periph_clk_en[4]) |-> s_prog [*4] ##1 periph_rst_release[4])
      else $error("i2c enable sequence wrong");
   AST_LOCKED_CAUSE: assert property ($rose(periph_clk_en[4]) |-> wr_age_q < 3'h4)
      else $error("i2c enabled without config write");
   AST_UNMAPPED_ZERO: assert property (s_rd(32'h02AC000C) |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   AST_RPT_RESERVED: assert property (s_rd(psc_pkg::ADDR_STATE_RPT) |=>
      reg_rdata[31:30] == 2'h0 && reg_rdata[5:0] == 6'h0) else $error("report reserved bits set");
endmodule
bind psc_top psc_top_sva psc_top_sva_inst (.clk(clk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .boot_select_pins(boot_select_pins),
   .static_pd_pins(static_pd_pins), .dram_pin_enable(dram_pin_enable), .async_pin_enable(async_pin_enable),
   .periph_clk_en(periph_clk_en), .periph_rst_release(periph_rst_release),
   .dram_ctrl_ready(dram_ctrl_ready), .async_mem_ready(async_mem_ready));

// File: testbench/psc_top_tb.sv
// self-checking bench for the peripheral state control bank
`timescale 1ns/1ns
module psc_top_tb;
   logic clk, rst, reg_sel, reg_wr, dram_pin_enable, async_pin_enable, dram_ctrl_ready, async_mem_ready;
   logic [31:0] reg_addr, reg_wdata, reg_rdata, exp;
   logic [3:0] boot_select_pins;
   logic [8:0] static_pd_pins, periph_clk_en, periph_rst_release;
   logic [3:0] boots [4] = '{4'h7, 4'h4, 4'h1, 4'h0};
   int mismatches, n_compared, n;
   psc_top psc_top_inst (.clk(clk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .boot_select_pins(boot_select_pins),
      .static_pd_pins(static_pd_pins), .dram_pin_enable(dram_pin_enable), .async_pin_enable(async_pin_enable),
      .periph_clk_en(periph_clk_en), .periph_rst_release(periph_rst_release),
      .dram_ctrl_ready(dram_ctrl_ready), .async_mem_ready(async_mem_ready));
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      n_compared++;
      if (seen !== want) begin
         mismatches++;
         $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
      end
   endtask
   // one register access, strobe high for one edge
   task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_sel <= 1'b1;
      reg_wr <= w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_sel <= 1'b0;
      reg_wr <= 1'b0;
   endtask
   // read and compare once the data has landed
   task automatic rd(input logic [31:0] a, input logic [31:0] want, input string what);
      access(1'b0, a, 32'h0);
      @(posedge clk);
      #1;
      check(reg_rdata, want, what);
   endtask
   // key, idle edges, then the locked write
   task automatic cfg_write(input int gap, input logic [31:0] d);
      access(1'b1, psc_pkg::ADDR_UNLOCK, psc_pkg::UNLOCK_KEY);
      repeat (gap) @(posedge clk);
      access(1'b1, psc_pkg::ADDR_PERIPH_CFG, d);
   endtask
   // reset with a boot code on the pins
   task automatic do_reset(input logic [3:0] b);
      @(posedge clk);
      rst <= 1'b1;
      boot_select_pins <= b;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
   endtask
   // counts and verdict
   task automatic wrap_up();
      $display("compared %0d, wrong %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // main sequence
   initial begin
      rst = 1'b1;
      reg_sel = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 32'h0;
      reg_wdata = 32'h0;
      boot_select_pins = 4'h0;
      static_pd_pins = 9'h080;
      dram_pin_enable = 1'b0;
      async_pin_enable = 1'b1;
      mismatches = 0;
      n_compared = 0;
      foreach (boots[i]) begin
         do_reset(boots[i]);
         repeat (20) @(posedge clk);
         exp = {11'h0, boots[i] == psc_pkg::BOOT_PCI, 1'b0, boots[i] == psc_pkg::BOOT_HOST_PORT, 18'h0};
         rd(psc_pkg::ADDR_UNLOCK, psc_pkg::UNLOCK_RESET, "key reset");
         rd(psc_pkg::ADDR_PERIPH_CFG, exp, "boot enables");
         rd(psc_pkg::ADDR_MEM_CFG, {31'h0, boots[i] == psc_pkg::BOOT_ASYNC_ROM}, "boot async");
         exp = {4'h0, boots[i] == psc_pkg::BOOT_HOST_PORT, 3'h3, 24'h0};
         rd(psc_pkg::ADDR_STATE_RPT, exp, "boot report");
         rd(psc_pkg::ADDR_PCI_RPT, {31'h0, boots[i] == psc_pkg::BOOT_PCI}, "pci report");
         exp = {23'h0, boots[i] == psc_pkg::BOOT_PCI, 1'b0, boots[i] == psc_pkg::BOOT_HOST_PORT, 6'h0};
         check({23'h0, periph_clk_en}, exp, "boot clocks");
         check({31'h0, async_mem_ready}, {31'h0, boots[i] == psc_pkg::BOOT_ASYNC_ROM}, "boot ready");
         $display("boot test done, code %h", boots[i]);
      end
      access(1'b1, psc_pkg::ADDR_PERIPH_CFG, 32'h00001000);
      cfg_write(15, 32'h00001000);
      rd(psc_pkg::ADDR_PERIPH_CFG, 32'h0, "locked write");
      cfg_write(14, 32'hFFFEFFFF);
      access(1'b1, psc_pkg::ADDR_PERIPH_CFG, 32'h0);
      rd(psc_pkg::ADDR_PERIPH_CFG, 32'h00145550, "window edge");
      $display("lock test done");
      for (int k = 0; k < 9; k++) begin
         cfg_write(0, 32'h1 << (4 + 2 * k));
         repeat (10) @(posedge clk);
         #1;
         // bit 16 is serial port 1 (index 7, pinned down), bit 18 is the host port (index 6)
         exp = (k == 6) ? 32'h0 : (k == 7) ? 32'h00000040 : 32'h1 << k;
         check({23'h0, periph_clk_en}, exp, "clock gate");
         check({23'h0, periph_rst_release}, exp, "reset release");
         exp = (k < 6) ? 32'h1 << (6 + 3 * k) : (k == 7) ? 32'h08000000 : 32'h0;
         rd(psc_pkg::ADDR_STATE_RPT, exp | 32'h03000000, "state fields");
         rd(psc_pkg::ADDR_PCI_RPT, {31'h0, k == 8}, "pci state");
      end
      $display("enable test done");
      access(1'b1, psc_pkg::ADDR_MEM_CFG, 32'h3);
      for (n = 0; n < 16 && async_mem_ready !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      check({31'h0, async_mem_ready}, 32'h1, "async ready");
      if (async_mem_ready !== 1'b1) wrap_up();
      check({31'h0, dram_ctrl_ready}, 32'h0, "dram strap");
      access(1'b1, psc_pkg::ADDR_MEM_CFG, 32'h0);
      access(1'b0, psc_pkg::ADDR_MEM_CFG, 32'h0);
      @(posedge clk);
      #1;
      check(reg_rdata, 32'h3, "sticky bit");
      check({31'h0, async_mem_ready}, 32'h1, "ready kept");
      access(1'b1, psc_pkg::ADDR_STATE_RPT, 32'hFFFFFFFF);
      rd(psc_pkg::ADDR_STATE_RPT, 32'h03000000, "report fixed");
      rd(32'h02AC000C, 32'h0, "unmapped");
      // swap the straps: dram allowed, async port pinned off
      do_reset(4'h0);
      dram_pin_enable <= 1'b1;
      async_pin_enable <= 1'b0;
      repeat (2) @(posedge clk);
      access(1'b1, psc_pkg::ADDR_MEM_CFG, 32'h3);
      for (n = 0; n < 16 && dram_ctrl_ready !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      check({31'h0, dram_ctrl_ready}, 32'h1, "dram ready");
      check({31'h0, async_mem_ready}, 32'h0, "async strap");
      $display("memory test done");
      wrap_up();
   end
endmodule
